// File: shared/aald_map.svh
// constants for the accumulator add/and decoder
// Functional notes
// - opcode bit 7 is msb; opcode byte first, immediate byte second.
// - 01101rrr adds working register r to accumulator, carry from sum.
// - 00000011 adds following byte to accumulator, sets carry, two cycles.
// - add-with-carry adds carry in, clears it, then adds operand, sets carry.
// - 0111000r adds carry and memory byte at low 6 (or 7) bits of r.
// - 00010011 adds carry and following byte, sets carry, two cycles.
// - 01011rrr ands working register r into the accumulator.
// - 0101000r ands memory byte at low 6 (or 7) bits of r into accumulator.
`ifndef AALD_MAP_SVH
`define AALD_MAP_SVH
`define AALD_OP_ADD_REG 5'b01101
`define AALD_OP_ADC_REG 5'b01111
`define AALD_OP_AND_REG 5'b01011
`define AALD_OP_ADD_IND 7'b0110000
`define AALD_OP_ADC_IND 7'b0111000
`define AALD_OP_AND_IND 7'b0101000
`define AALD_OP_ADD_IMM 8'h03
`define AALD_OP_ADC_IMM 8'h13
`define AALD_ACC_RESET 8'h00
`define AALD_CY_RESET 1'b0
`define AALD_PTR_SMALL 6
`define AALD_PTR_LARGE 7
`endif

// File: shared/aald_pkg.sv
// types for the accumulator add/and decoder
package aald_pkg;
    typedef enum logic [1:0] {
        AALD_ALU_ADD,
        AALD_ALU_AND,
        AALD_ALU_PASS
    } aald_alu_op_t;
    typedef enum logic [2:0] {
        AALD_SRC_NONE,
        AALD_SRC_REG,
        AALD_SRC_MEM,
        AALD_SRC_IMM
    } aald_src_t;
    typedef struct packed {
        logic valid;
        aald_alu_op_t op;
        aald_src_t src;
        logic use_carry;
        logic [2:0] working_register_sel;
    } aald_dec_t;
    typedef struct packed {
        logic [7:0] acc;
        logic carry;
    } aald_result_t;
endpackage : aald_pkg

// File: rtl/aald_alu.sv
// add/and arithmetic for the accumulator
`timescale 1ns/1ps
`include "aald_map.svh"
module aald_alu (
    // operands
    input wire logic [7:0] acc,
    input wire logic carry_in,
    input wire logic [7:0] operand,
    input wire aald_pkg::aald_alu_op_t op,
    input wire logic use_carry,
    // result
    output aald_pkg::aald_result_t result
);
    import aald_pkg::*;
    logic [8:0] pre;
    logic [8:0] sum;
    always_comb begin
        // carry folded in first; its overflow is discarded as carry is cleared
        pre = {1'b0, acc} + {8'h00, (use_carry & carry_in)};
        sum = {1'b0, pre[7:0]} + {1'b0, operand};
        result.acc = acc;
        result.carry = carry_in;
        unique case (op)
            AALD_ALU_ADD: begin
                result.acc = sum[7:0];
                result.carry = sum[8];
            end
            AALD_ALU_AND: begin
                result.acc = acc & operand;
            end
            AALD_ALU_PASS: begin
                result.acc = acc;
            end
            default: begin
                result.acc = acc;
            end
        endcase
    end
endmodule : aald_alu

// File: rtl/aald_decoder.sv
// decoder and executor for accumulator add / and instructions
`timescale 1ns/1ps
`include "aald_map.svh"
module aald_decoder (
    // clock and reset
    input wire logic MCLK,
    input wire logic RSTN,
    // memory variant: high selects 7-bit indirect pointer
    input wire logic LARGE_MEM,
    // program byte stream
    input wire logic PROG_VALID,
    input wire logic [7:0] PROG_BYTE,
    // working register file read
    output logic [2:0] REG_ADDR,
    input wire logic [7:0] REG_DATA,
    // data memory read
    output logic MEM_RD,
    output logic [6:0] MEM_ADDR,
    input wire logic [7:0] MEM_DATA,
    // architectural state
    output logic [7:0] ACC,
    output logic CARRY,
    output logic BUSY,
    output logic DONE,
    output logic ILLEGAL
);
    import aald_pkg::*;

    typedef enum logic [1:0] {
        AALD_ST_FETCH,
        AALD_ST_OPERAND,
        AALD_ST_EXEC
    } aald_state_t;

    ////////////////////////////////////////////////////////////////////////
    aald_state_t state;
    aald_dec_t dec;
    aald_dec_t cur;
    aald_result_t res;
    logic [7:0] operand;
    logic [7:0] imm;
    logic mem_wait;
    logic exec_fire;

    // decode of the opcode byte; bit 7 is the msb
    always_comb begin
        dec = '{valid: 1'b0, op: AALD_ALU_PASS, src: AALD_SRC_NONE,
                use_carry: 1'b0, working_register_sel: PROG_BYTE[2:0]};
        if (PROG_BYTE[7:3] == `AALD_OP_ADD_REG) begin
            dec.valid = 1'b1;
            dec.op = AALD_ALU_ADD;
            dec.src = AALD_SRC_REG;
        end else if (PROG_BYTE[7:3] == `AALD_OP_ADC_REG) begin
            dec.valid = 1'b1;
            dec.op = AALD_ALU_ADD;
            dec.src = AALD_SRC_REG;
            dec.use_carry = 1'b1;
        end else if (PROG_BYTE[7:3] == `AALD_OP_AND_REG) begin
            dec.valid = 1'b1;
            dec.op = AALD_ALU_AND;
            dec.src = AALD_SRC_REG;
        end else if (PROG_BYTE[7:1] == `AALD_OP_ADD_IND) begin
            dec.valid = 1'b1;
            dec.op = AALD_ALU_ADD;
            dec.src = AALD_SRC_MEM;
            dec.working_register_sel = {2'b00, PROG_BYTE[0]};
        end else if (PROG_BYTE[7:1] == `AALD_OP_ADC_IND) begin
            dec.valid = 1'b1;
            dec.op = AALD_ALU_ADD;
            dec.src = AALD_SRC_MEM;
            dec.use_carry = 1'b1;
            dec.working_register_sel = {2'b00, PROG_BYTE[0]};
        end else if (PROG_BYTE[7:1] == `AALD_OP_AND_IND) begin
            dec.valid = 1'b1;
            dec.op = AALD_ALU_AND;
            dec.src = AALD_SRC_MEM;
            dec.working_register_sel = {2'b00, PROG_BYTE[0]};
        end else if (PROG_BYTE == `AALD_OP_ADD_IMM) begin
            dec.valid = 1'b1;
            dec.op = AALD_ALU_ADD;
            dec.src = AALD_SRC_IMM;
        end else if (PROG_BYTE == `AALD_OP_ADC_IMM) begin
            dec.valid = 1'b1;
            dec.op = AALD_ALU_ADD;
            dec.src = AALD_SRC_IMM;
            dec.use_carry = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer: register ops fetch operand one cycle, immediates wait a byte
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            state <= AALD_ST_FETCH;
            cur <= '0;
            imm <= 8'h00;
        end else begin
            unique case (state)
                AALD_ST_FETCH: begin
                    if (PROG_VALID && dec.valid) begin
                        cur <= dec;
                        // immediate forms need a second byte
                        state <= (dec.src == AALD_SRC_IMM) ? AALD_ST_OPERAND : AALD_ST_EXEC;
                    end
                end
                AALD_ST_OPERAND: begin
                    if (PROG_VALID) begin
                        imm <= PROG_BYTE;
                        state <= AALD_ST_EXEC;
                    end
                end
                AALD_ST_EXEC: begin
                    // indirect forms stay here until the memory read lands
                    if (!mem_wait) begin
                        state <= AALD_ST_FETCH;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // operand addressing; pointer register read first, memory next cycle
    logic ptr_phase;
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            REG_ADDR <= 3'h0;
            MEM_RD <= 1'b0;
            MEM_ADDR <= 7'h00;
            ptr_phase <= 1'b0;
        end else begin
            MEM_RD <= 1'b0;
            ptr_phase <= 1'b0;
            if (state == AALD_ST_FETCH && PROG_VALID && dec.valid) begin
                REG_ADDR <= dec.working_register_sel;
                ptr_phase <= (dec.src == AALD_SRC_MEM);
            end
            if (ptr_phase) begin
                // pointer width depends on memory size
                MEM_ADDR <= LARGE_MEM ? REG_DATA[6:0] : {1'b0, REG_DATA[5:0]};
                MEM_RD <= 1'b1;
            end
        end
    end

    // indirect forms hold exec one more cycle until memory data returns
    assign mem_wait = (cur.src == AALD_SRC_MEM) && !MEM_RD;

    always_comb begin
        unique case (cur.src)
            AALD_SRC_REG: operand = REG_DATA;
            AALD_SRC_MEM: operand = MEM_DATA;
            AALD_SRC_IMM: operand = imm;
            default: operand = 8'h00;
        endcase
    end

    aald_alu u_alu (
        .acc(ACC),
        .carry_in(CARRY),
        .operand(operand),
        .op(cur.op),
        .use_carry(cur.use_carry),
        .result(res)
    );

    ////////////////////////////////////////////////////////////////////////
    // architectural write-back
    assign exec_fire = (state == AALD_ST_EXEC) && !mem_wait;
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            ACC <= `AALD_ACC_RESET;
            CARRY <= `AALD_CY_RESET;
        end else if (exec_fire) begin
            ACC <= res.acc;
            CARRY <= res.carry;
        end
    end

    // status outputs
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            BUSY <= 1'b0;
            DONE <= 1'b0;
            ILLEGAL <= 1'b0;
        end else begin
            DONE <= exec_fire;
            BUSY <= (state != AALD_ST_FETCH) || (PROG_VALID && dec.valid);
            ILLEGAL <= (state == AALD_ST_FETCH) && PROG_VALID && !dec.valid;
        end
    end
endmodule : aald_decoder

// File: bench/aald_decoder_properties.sv
// port-level checks for the accumulator add/and decoder
`timescale 1ns/1ps
module aald_decoder_props (
    // clock and reset
    input wire logic MCLK,
    input wire logic RSTN,
    // stimulus
    input wire logic LARGE_MEM,
    input wire logic PROG_VALID,
    input wire logic [7:0] PROG_BYTE,
    // results
    input wire logic MEM_RD,
    input wire logic [6:0] MEM_ADDR,
    input wire logic [7:0] ACC,
    input wire logic CARRY,
    input wire logic BUSY,
    input wire logic DONE,
    input wire logic ILLEGAL
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RSTN);
    ////////////////////////////////////////////////////////////////
    // opcode accepted only while idle
    sequence s_take;
        !BUSY && PROG_VALID;
    endsequence
    sequence s_reg;
        s_take ##0 (PROG_BYTE[7:3] inside {5'b01101, 5'b01111, 5'b01011});
    endsequence
    sequence s_and;
        s_take ##0 PROG_BYTE[7:3] == 5'b01011;
    endsequence
    sequence s_ind;
        s_take ##0 (PROG_BYTE[7:1] inside {7'b0110000, 7'b0111000, 7'b0101000});
    endsequence
    sequence s_imm_pair;
        s_take ##0 (PROG_BYTE == 8'h03 || PROG_BYTE == 8'h13) ##1 PROG_VALID;
    endsequence
    ////////////////////////////////////////////////////////////////
    AST_REG_DONE: assert property (s_reg |-> ##[1:3] DONE)
        else $error("register op without done");
    AST_IMM_TWO: assert property (s_imm_pair |-> !DONE ##[1:3] DONE)
        else $error("immediate op timing wrong");
    AST_AND_CARRY: assert property (s_and |=> $stable(CARRY) [*3])
        else $error("and changed carry");
    AST_IND_READ: assert property (s_ind |-> ##[1:3] MEM_RD)
        else $error("indirect op without memory read");
    AST_PTR_SMALL: assert property (MEM_RD && !LARGE_MEM |-> !MEM_ADDR[6])
        else $error("small pointer used bit 6");
    AST_RD_PULSE: assert property (MEM_RD |=> !MEM_RD)
        else $error("memory read longer than one cycle");
    AST_DONE_PULSE: assert property (DONE |=> !DONE)
        else $error("done longer than one cycle");
    AST_ILL_KEEP: assert property (ILLEGAL |-> $stable(ACC) && $stable(CARRY))
        else $error("ignored opcode changed state");
endmodule : aald_decoder_props

bind aald_decoder aald_decoder_props u_props (.MCLK(MCLK), .RSTN(RSTN), .LARGE_MEM(LARGE_MEM),
    .PROG_VALID(PROG_VALID), .PROG_BYTE(PROG_BYTE), .MEM_RD(MEM_RD), .MEM_ADDR(MEM_ADDR),
    .ACC(ACC), .CARRY(CARRY), .BUSY(BUSY), .DONE(DONE), .ILLEGAL(ILLEGAL));

// File: bench/accum_add_and_logic_decode_tb_top.sv
// self-checking bench for the accumulator add/and decoder
`timescale 1ns/1ps
module accum_add_and_logic_decode_tb_top;
    logic MCLK, RSTN, LARGE_MEM, PROG_VALID, MEM_RD, CARRY, BUSY, DONE, ILLEGAL, ecy;
    logic [7:0] PROG_BYTE, ACC, eacc;
    logic [2:0] REG_ADDR;
    logic [6:0] MEM_ADDR;
    logic [7:0] regs [8];
    logic [7:0] mem [128];
    int bad_count = 0;
    int n_tests = 0;
    aald_decoder dut (.MCLK(MCLK), .RSTN(RSTN), .LARGE_MEM(LARGE_MEM), .PROG_VALID(PROG_VALID),
        .PROG_BYTE(PROG_BYTE), .REG_ADDR(REG_ADDR), .REG_DATA(regs[REG_ADDR]), .MEM_RD(MEM_RD),
        .MEM_ADDR(MEM_ADDR), .MEM_DATA(mem[MEM_ADDR]), .ACC(ACC), .CARRY(CARRY),
        .BUSY(BUSY), .DONE(DONE), .ILLEGAL(ILLEGAL));
    initial begin
        MCLK = 1'b0;
        forever #10 MCLK = ~MCLK;
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // carry-in overflow dropped, final carry from operand sum
    task automatic add_exp(input logic [7:0] v, input logic wc);
        logic [7:0] t;
        t = eacc + {7'h00, wc & ecy};
        {ecy, eacc} = {1'b0, t} + {1'b0, v};
    endtask : add_exp
    task automatic issue(input logic [7:0] op, input logic two, input logic [7:0] imm);
        @(negedge MCLK);
        PROG_VALID = 1'b1;
        PROG_BYTE = op;
        @(negedge MCLK);
        PROG_VALID = two;
        PROG_BYTE = imm;
        @(negedge MCLK);
        PROG_VALID = 1'b0;
        for (int i = 0; i < 6 && DONE !== 1'b1; i++) @(negedge MCLK);
        chk({DONE, ACC, CARRY}, {1'b1, eacc, ecy});
    endtask : issue
    ////////////////////////////////////////////////////////////////
    task automatic t_reg;
        for (int r = 0; r < 8; r++) begin
            regs[r] = 8'h3b + 8'(r * 23);
            add_exp(regs[r], 1'b0);
            issue({5'b01101, 3'(r)}, 1'b0, 8'h00);
            add_exp(regs[r], 1'b1);
            issue({5'b01111, 3'(r)}, 1'b0, 8'h00);
            eacc = eacc & regs[r];
            issue({5'b01011, 3'(r)}, 1'b0, 8'h00);
        end
    endtask : t_reg
    task automatic t_imm;
        add_exp(8'hff, 1'b0);
        issue(8'h03, 1'b1, 8'hff);
        add_exp(8'hc7, 1'b1);
        issue(8'h13, 1'b1, 8'hc7);
    endtask : t_imm
    // pointer values carry bit 6 so the small variant must mask it
    task automatic t_ind;
        logic [6:0] a;
        regs[0] = 8'hd5;
        regs[1] = 8'hfa;
        for (int k = 0; k < 4; k++) begin
            LARGE_MEM = k[1];
            a = k[1] ? regs[k[0]][6:0] : {1'b0, regs[k[0]][5:0]};
            add_exp(mem[a], 1'b0);
            issue({7'b0110000, k[0]}, 1'b0, 8'h00);
            add_exp(mem[a], 1'b1);
            issue({7'b0111000, k[0]}, 1'b0, 8'h00);
            eacc = eacc & mem[a];
            issue({7'b0101000, k[0]}, 1'b0, 8'h00);
        end
    endtask : t_ind
    task automatic t_bad;
        @(negedge MCLK);
        PROG_VALID = 1'b1;
        PROG_BYTE = 8'h27;
        @(negedge MCLK);
        PROG_VALID = 1'b0;
        for (int i = 0; i < 4 && ILLEGAL !== 1'b1; i++) @(negedge MCLK);
        chk({ILLEGAL, ACC, CARRY}, {1'b1, eacc, ecy});
    endtask : t_bad
    task automatic test_done;
        $display("compares %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////
    initial begin
        RSTN = 1'b0;
        LARGE_MEM = 1'b0;
        PROG_VALID = 1'b0;
        PROG_BYTE = 8'h00;
        eacc = 8'h00;
        ecy = 1'b0;
        for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37 + 11);
        for (int i = 0; i < 8; i++) regs[i] = 8'h00;
        repeat (10) @(negedge MCLK);
        chk({BUSY, ACC, CARRY}, 10'h000);
        RSTN = 1'b1;
        t_reg();
        t_imm();
        t_ind();
        t_bad();
        test_done();
    end
    initial begin
        #20us;
        bad_count++;
        test_done();
    end
endmodule : accum_add_and_logic_decode_tb_top
